// ==== rtl/pirqc_top.sv ====
// prioritized interrupt controller with flag banks and avalon-mm slave
module pirqc_top #(
  parameter bit REPRODUCE_ANOMALY = 1'b0
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [pirqc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt pins, active low, asynchronous
  input wire logic [pirqc_pkg::NUM_SRC-1:0] irq_line_n,
  // peripheral events ored onto sources 3 and 4
  input wire logic [pirqc_pkg::NUM_EVT-1:0] evt_in,
  // core sequencer
  input wire logic instr_done,
  input wire logic return_from_irq,
  input wire logic sleep_in,
  input wire logic opt_zero_wr_busy,
  input wire logic [1:0] opt_zero_wr_cycle,
  input wire logic flag_wr,
  input wire pirqc_pkg::pirqc_flags_s flag_in,
  output pirqc_pkg::pirqc_core_s core_out,
  output pirqc_pkg::pirqc_flags_s flag_out,
  output pirqc_pkg::pirqc_bank_e bank_out,
  output logic wake
);
  import pirqc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] pin_meta_reg;
  logic [NUM_SRC-1:0] pin_sync_reg;
  logic [NUM_SRC-1:0] pin_prev_reg;
  logic [NUM_SRC-1:0] fall;
  logic [NUM_SRC-1:0] rise;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
      pin_prev_reg <= PIN_IDLE;
    end else if (clk_en) begin
      pin_meta_reg <= irq_line_n;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign fall = pin_prev_reg & ~pin_sync_reg;
  assign rise = ~pin_prev_reg & pin_sync_reg;

  // ------------------------------------------------------------
  // option register: bus copy plus the copy in force
  // ------------------------------------------------------------
  logic [7:0] opt_shadow_reg;
  logic [7:0] opt_reg;
  logic bus_wr;
  logic bus_rd;
  logic gen;
  logic gen_next;
  logic src1_level_select;
  logic src2_edge_polarity;

  assign bus_wr = avs_write && !avs_waitrequest;
  assign bus_rd = avs_read && !avs_waitrequest;
  assign gen = opt_reg[OPT_GEN_BIT];
  assign src1_level_select = opt_reg[OPT_LES_BIT];
  assign src2_edge_polarity = opt_reg[OPT_ESB_BIT];
  // the boundary samples with the value that is about to be put in force
  assign gen_next = opt_shadow_reg[OPT_GEN_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      opt_shadow_reg <= OPT_RESET;
    end else if (clk_en && bus_wr && avs_address == ADDR_OPT) begin
      opt_shadow_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      opt_reg <= OPT_RESET;
    end else if (clk_en && instr_done) begin
      opt_reg <= opt_shadow_reg;
    end
  end

  // ------------------------------------------------------------
  // request latches and event flags
  // ------------------------------------------------------------
  logic nmi_latch_reg;
  logic src1_edge_reg;
  logic src2_edge_reg;
  logic [NUM_EVT-1:0] evt_flag_reg;
  logic [3:0] mreq;
  logic [2:0] pick;
  logic take_nmi;
  logic take_mask;
  pirqc_mode_e mode_reg;

  // set wins over the clear that entry gives
  always_ff @(posedge clk) begin
    if (srst) begin
      nmi_latch_reg <= 1'b0;
    end else if (clk_en) begin
      nmi_latch_reg <= fall[0] || (nmi_latch_reg && !take_nmi);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      src1_edge_reg <= 1'b0;
    end else if (clk_en) begin
      // level mode stores nothing
      src1_edge_reg <= !src1_level_select && (fall[1]
        || (src1_edge_reg && !(take_mask && pick == 3'h1)));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      src2_edge_reg <= 1'b0;
    end else if (clk_en) begin
      src2_edge_reg <= (src2_edge_polarity ? rise[2] : fall[2])
        || (src2_edge_reg && !(take_mask && pick == 3'h2));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      evt_flag_reg <= '0;
    end else if (clk_en) begin
      evt_flag_reg <= evt_in | (evt_flag_reg & ~((bus_wr && avs_address == ADDR_EVT)
        ? avs_writedata[NUM_EVT-1:0] : '0));
    end
  end

  // level sources are seen only while the line is low at the boundary
  always_comb begin
    mreq[0] = src1_level_select ? !pin_sync_reg[1] : src1_edge_reg;
    mreq[1] = src2_edge_reg;
    mreq[2] = !pin_sync_reg[3] || (|evt_flag_reg[1:0]);
    mreq[3] = !pin_sync_reg[4] || (|evt_flag_reg[3:2]);
  end

  assign pick = pirqc_pick(gen_next ? mreq : 4'h0);

  // ------------------------------------------------------------
  // arbitration at the instruction boundary
  // ------------------------------------------------------------
  logic in_nmi;
  logic anom_pend_reg;

  assign in_nmi = (mode_reg == MODE_NMI_I) || (mode_reg == MODE_NMI_N);
  // a return in the same cycle wins; the next boundary sees the new mode
  assign take_nmi = instr_done && nmi_latch_reg && !in_nmi && !return_from_irq;
  assign take_mask = instr_done && !take_nmi && !return_from_irq
    && mode_reg == MODE_NORM && pick != 3'h0;

  // remembers a request seen in the unsafe part of an option-zero write
  always_ff @(posedge clk) begin
    if (srst) begin
      anom_pend_reg <= 1'b0;
    end else if (clk_en) begin
      if (instr_done) begin
        anom_pend_reg <= 1'b0;
      end else if (opt_zero_wr_busy && opt_zero_wr_cycle < ANOM_CYCLES
        && mode_reg == MODE_NORM && |(gen ? mreq : 4'h0)) begin
        anom_pend_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // mode, flag bank and core hand-off
  // ------------------------------------------------------------
  pirqc_bank_e bank_reg;
  pirqc_bank_e bank_next;
  pirqc_mode_e mode_next;
  logic pop_ok;
  pirqc_flags_s flag_bank_reg [3];

  assign pop_ok = return_from_irq && mode_reg != MODE_NORM;

  always_comb begin
    mode_next = mode_reg;
    bank_next = bank_reg;
    if (take_nmi) begin
      mode_next = (mode_reg == MODE_IRQ) ? MODE_NMI_I : MODE_NMI_N;
      bank_next = BANK_NMI;
    end else if (take_mask) begin
      mode_next = MODE_IRQ;
      // the anomaly switches mode but keeps the normal flags
      bank_next = (REPRODUCE_ANOMALY && anom_pend_reg) ? BANK_NORM : BANK_IRQ;
    end else if (return_from_irq) begin
      case (mode_reg)
        MODE_NMI_I: begin
          mode_next = MODE_IRQ;
          bank_next = BANK_IRQ;
        end
        MODE_NMI_N, MODE_IRQ: begin
          mode_next = MODE_NORM;
          bank_next = BANK_NORM;
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= MODE_NORM;
      bank_reg <= BANK_NORM;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      bank_reg <= bank_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_out <= '0;
    end else if (clk_en) begin
      core_out.take <= take_nmi || take_mask;
      core_out.push_pc <= take_nmi || take_mask;
      core_out.pop_pc <= pop_ok;
      if (take_nmi || take_mask) begin
        core_out.vector <= pirqc_vector(take_nmi ? 3'h0 : pick);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 3; i++) begin
        flag_bank_reg[i] <= '0;
      end
      flag_out <= '0;
    end else if (clk_en) begin
      if (flag_wr) begin
        flag_bank_reg[bank_reg] <= flag_in;
      end
      flag_out <= (flag_wr && bank_next == bank_reg) ? flag_in : flag_bank_reg[bank_next];
    end
  end

  assign bank_out = bank_reg;

  // stays asleep unless enabled, even with an nmi pending
  always_ff @(posedge clk) begin
    if (srst) begin
      wake <= 1'b0;
    end else if (clk_en) begin
      wake <= sleep_in && gen && (nmi_latch_reg || |mreq);
    end
  end

  // ------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the answer
  // ------------------------------------------------------------
  logic [31:0] stat_word;

  always_comb begin
    stat_word = RD_ZERO;
    stat_word[STAT_MODE_LSB +: 2] = mode_reg;
    stat_word[STAT_BANK_LSB +: 2] = bank_reg;
    stat_word[STAT_PEND_LSB +: 5] = {mreq, nmi_latch_reg};
    stat_word[STAT_WAKE_BIT] = wake;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= RD_ZERO;
    end else if (clk_en) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          ADDR_STAT: avs_readdata <= stat_word;
          ADDR_EVT: avs_readdata <= {{(32 - NUM_EVT){1'b0}}, evt_flag_reg};
          default: avs_readdata <= RD_ZERO; // option register is write-only
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_nmi_vector;
    (clk_en && take_nmi) |=> (core_out.take && core_out.vector == VEC_SRC0);
  endproperty
  a_nmi_vector: assert property (p_nmi_vector) else $error("nmi entry, wrong vector");
  property p_no_nest;
    (clk_en && mode_reg == MODE_IRQ) |=> !(core_out.take && core_out.vector != VEC_SRC0);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("maskable nested in maskable");
  property p_src1_first;
    (clk_en && take_mask && mreq[0]) |=> core_out.vector == VEC_SRC1;
  endproperty
  a_src1_first: assert property (p_src1_first) else $error("source 1 not first");
  property p_gen_blocks;
    (clk_en && instr_done && !gen_next && !nmi_latch_reg) |=> !core_out.take;
  endproperty
  a_gen_blocks: assert property (p_gen_blocks) else $error("taken while disabled");
  property p_wake_gated;
    (clk_en && !gen) |=> !wake;
  endproperty
  a_wake_gated: assert property (p_wake_gated) else $error("wake while disabled");
  property p_nmi_clear;
    (clk_en && take_nmi && !fall[0]) |=> !nmi_latch_reg ##1 (!core_out.take || nmi_latch_reg);
  endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("nmi latch not cleared");
  property p_src2_rise;
    (clk_en && src2_edge_polarity && rise[2]) |=> src2_edge_reg;
  endproperty
  a_src2_rise: assert property (p_src2_rise) else $error("source 2 rise lost");
  property p_ret_irq;
    (clk_en && return_from_irq && mode_reg == MODE_IRQ)
      |=> (mode_reg == MODE_NORM && bank_reg == BANK_NORM && core_out.pop_pc);
  endproperty
  a_ret_irq: assert property (p_ret_irq) else $error("return left wrong bank");
  property p_nmi_bank;
    (core_out.take && core_out.vector == VEC_SRC0) |-> bank_reg == BANK_NMI;
  endproperty
  a_nmi_bank: assert property (p_nmi_bank) else $error("nmi entry without nmi bank");
  property p_evt_flag;
    (clk_en && evt_in[0]) |=> evt_flag_reg[0];
  endproperty
  a_evt_flag: assert property (p_evt_flag) else $error("event flag lost");
  property p_opt_apply;
    (clk_en && instr_done) |=> opt_reg == $past(opt_shadow_reg);
  endproperty
  a_opt_apply: assert property (p_opt_apply) else $error("option not applied");
  c_nmi_in_irq: cover property (take_nmi && mode_reg == MODE_IRQ);
  c_mask_take: cover property (take_mask);
  c_wake: cover property (wake);
  c_anom: cover property (anom_pend_reg && take_mask);

endmodule

// ==== rtl/pirqc_pkg.sv ====
// shared constants, types and helpers of the prioritized interrupt controller
package pirqc_pkg;

  // ------------------------------------------------------------
  // vectors, one per source, index 0 is the non-maskable one
  // ------------------------------------------------------------
  localparam int unsigned VEC_W = 12;
  localparam logic [11:0] VEC_SRC0 = 12'hffc;
  localparam logic [11:0] VEC_SRC1 = 12'hff6;
  localparam logic [11:0] VEC_SRC2 = 12'hff4;
  localparam logic [11:0] VEC_SRC3 = 12'hff2;
  localparam logic [11:0] VEC_SRC4 = 12'hff0;

  // ------------------------------------------------------------
  // register map (byte addresses) and field layout
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_OPT = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_EVT = 4'h8;
  localparam int unsigned OPT_LES_BIT = 6;
  localparam int unsigned OPT_ESB_BIT = 5;
  localparam int unsigned OPT_GEN_BIT = 4;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_BANK_LSB = 2;
  localparam int unsigned STAT_PEND_LSB = 4;
  localparam int unsigned STAT_WAKE_BIT = 9;
  localparam int unsigned NUM_EVT = 4;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ------------------------------------------------------------
  // pins and timing
  // ------------------------------------------------------------
  localparam int unsigned NUM_SRC = 5;
  localparam logic [4:0] PIN_IDLE = 5'h1f;
  localparam logic [1:0] ANOM_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    MODE_NORM  = 2'b00,
    MODE_IRQ   = 2'b01,
    MODE_NMI_I = 2'b11,
    MODE_NMI_N = 2'b10
  } pirqc_mode_e;

  typedef enum logic [1:0] {
    BANK_NORM = 2'b00,
    BANK_IRQ  = 2'b01,
    BANK_NMI  = 2'b10
  } pirqc_bank_e;

  typedef struct packed {
    logic take;
    logic push_pc;
    logic pop_pc;
    logic [11:0] vector;
  } pirqc_core_s;

  typedef struct packed {
    logic carry;
    logic zero;
  } pirqc_flags_s;

  // highest pending maskable source, 1 first, 0 when none
  function automatic logic [2:0] pirqc_pick(input logic [3:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i + 1);
      end
    end
    return idx;
  endfunction

  function automatic logic [11:0] pirqc_vector(input logic [2:0] idx);
    case (idx)
      3'h1: return VEC_SRC1;
      3'h2: return VEC_SRC2;
      3'h3: return VEC_SRC3;
      3'h4: return VEC_SRC4;
      default: return VEC_SRC0;
    endcase
  endfunction

endpackage

// ==== verification/pirqc_core_model.sv ====
// partner model: core sequencer boundaries and interrupt source lines
module pirqc_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench controls
  input wire logic run,
  input wire logic ret_req,
  input wire logic [4:0] pin_n,
  input wire logic [4:0] hold_lvl,
  // block side
  input wire pirqc_pkg::pirqc_core_s core_out,
  output logic instr_done,
  output logic return_from_irq,
  output logic [4:0] irq_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import pirqc_pkg::*;

  localparam logic [11:0] VECS [5] = '{VEC_SRC0, VEC_SRC1, VEC_SRC2, VEC_SRC3, VEC_SRC4};
  logic [1:0] cnt_reg;
  logic ret_reg;
  logic [4:0] held_reg;

  // one boundary every fourth cycle; a return retires at the next boundary
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 2'h0;
      instr_done <= 1'h0;
      ret_reg <= 1'h0;
      return_from_irq <= 1'h0;
    end else begin
      if (run) cnt_reg <= cnt_reg + 2'h1;
      instr_done <= run && cnt_reg == 2'h3;
      return_from_irq <= run && cnt_reg == 2'h3 && ret_reg;
      if (ret_req) ret_reg <= 1'h1;
      else if (run && cnt_reg == 2'h3) ret_reg <= 1'h0;
    end
  end

  // a level source stores nothing, so it keeps its line low until served
  always_ff @(posedge clk) begin
    if (srst) begin
      held_reg <= 5'h00;
      irq_line_n <= 5'h1f;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (hold_lvl[i]) held_reg[i] <= 1'h1;
        else if (core_out.take && core_out.vector == VECS[i]) held_reg[i] <= 1'h0;
      end
      irq_line_n <= pin_n & ~held_reg;
    end
  end
endmodule

// ==== verification/test_pirqc_top.sv ====
// self-checking bench of the prioritized interrupt controller
module test_pirqc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pirqc_pkg::*;

  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] irq_line_n;
  logic [3:0] evt_in = 4'h0;
  logic instr_done;
  logic return_from_irq;
  logic sleep_in = 1'h0;
  logic opt_zero_wr_busy = 1'h0;
  logic [1:0] opt_zero_wr_cycle = 2'h0;
  logic flag_wr = 1'h0;
  pirqc_flags_s flag_in = '0;
  pirqc_core_s core_out;
  pirqc_flags_s flag_out;
  pirqc_bank_e bank_out;
  logic wake;
  logic run = 1'h0;
  logic ret_req = 1'h0;
  logic [4:0] pin_n = 5'h1f;
  logic [4:0] hold_lvl = 5'h00;
  int failures = 0;
  int checks_done = 0;

  always #2.5 clk = ~clk;

  pirqc_top pirqc_top_i (
    .clk(clk), .srst(srst), .clk_en(1'h1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_line_n(irq_line_n), .evt_in(evt_in),
    .instr_done(instr_done), .return_from_irq(return_from_irq), .sleep_in(sleep_in),
    .opt_zero_wr_busy(opt_zero_wr_busy), .opt_zero_wr_cycle(opt_zero_wr_cycle),
    .flag_wr(flag_wr),
    .flag_in(flag_in), .core_out(core_out), .flag_out(flag_out),
    .bank_out(bank_out), .wake(wake)
  );

  pirqc_core_model pirqc_core_model_i (
    .clk(clk), .srst(srst), .run(run), .ret_req(ret_req), .pin_n(pin_n),
    .hold_lvl(hold_lvl), .core_out(core_out), .instr_done(instr_done),
    .return_from_irq(return_from_irq), .irq_line_n(irq_line_n)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a read compares against d; the extra edge keeps requests apart
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    if (!w) check(avs_readdata, d);
    check(avs_waitrequest, 1'h0);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask

  task automatic pulse(input int i);
    pin_n[i] <= 1'h0;
    repeat (4) @(posedge clk);
    pin_n[i] <= 1'h1;
    @(posedge clk);
  endtask

  task automatic wait_take(input logic [11:0] vec, input logic [1:0] bk);
    int n;
    n = 0;
    run <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (core_out.take !== 1'h1 && n < 200);
    check(core_out.take, 1'h1);
    check(core_out.vector, vec);
    check(core_out.push_pc, 1'h1);
    check(bank_out, bk);
  endtask

  task automatic no_take(input int c);
    logic seen;
    seen = 1'h0;
    repeat (c) begin
      @(posedge clk);
      if (core_out.take === 1'h1) seen = 1'h1;
    end
    check(seen, 1'h0);
  endtask

  // a written option value only comes into force once a boundary has passed
  task automatic boundary;
    run <= 1'h1;
    no_take(8);
  endtask

  // boundaries stop once the pop is seen, so a pending source cannot hide the bank
  task automatic do_ret(input logic [1:0] bk);
    int n;
    n = 0;
    run <= 1'h1;
    ret_req <= 1'h1;
    @(posedge clk);
    ret_req <= 1'h0;
    do begin
      @(posedge clk);
      n++;
    end while (core_out.pop_pc !== 1'h1 && n < 20);
    run <= 1'h0;
    check(core_out.pop_pc, 1'h1);
    check(bank_out, bk);
    @(posedge clk);
  endtask

  task automatic nmi_sleep(input logic exp);
    logic w;
    w = 1'h0;
    boundary();
    run <= 1'h0;
    sleep_in <= 1'h1;
    pulse(0);
    repeat (12) begin
      @(posedge clk);
      if (wake === 1'h1) w = 1'h1;
    end
    check(w, exp);
    sleep_in <= 1'h0;
    wait_take(VEC_SRC0, BANK_NMI);
    no_take(20);
    do_ret(BANK_NORM);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check(avs_waitrequest, 1'h1);
    check(bank_out, BANK_NORM);
    hold_lvl <= 5'h08;
    run <= 1'h1;
    @(posedge clk);
    hold_lvl <= 5'h00;
    no_take(24);
    bus(1'h1, ADDR_OPT, 32'h0000_00ff);
    wait_take(VEC_SRC3, BANK_IRQ);
    bus(1'h0, ADDR_OPT, RD_ZERO);
    bus(1'h0, 4'hc, RD_ZERO);
    bus(1'h1, ADDR_OPT, 32'h0000_0000);
    do_ret(BANK_NORM);
  endtask

  task automatic t_prio;
    bus(1'h1, ADDR_OPT, 32'h0000_0040);
    hold_lvl <= 5'h1a;
    run <= 1'h1;
    @(posedge clk);
    hold_lvl <= 5'h00;
    no_take(24);
    flag_wr <= 1'h1;
    flag_in <= 2'h3;
    @(posedge clk);
    flag_wr <= 1'h0;
    bus(1'h1, ADDR_OPT, 32'h0000_0050);
    check(flag_out, 2'h3);
    wait_take(VEC_SRC1, BANK_IRQ);
    check(flag_out, 2'h0);
    no_take(24);
    do_ret(BANK_NORM);
    check(flag_out, 2'h3);
    wait_take(VEC_SRC3, BANK_IRQ);
    do_ret(BANK_NORM);
    wait_take(VEC_SRC4, BANK_IRQ);
    pulse(0);
    wait_take(VEC_SRC0, BANK_NMI);
    do_ret(BANK_IRQ);
    do_ret(BANK_NORM);
  endtask

  task automatic t_edge;
    bus(1'h1, ADDR_OPT, 32'h0000_0030);
    boundary();
    pulse(1);
    wait_take(VEC_SRC1, BANK_IRQ);
    pulse(1);
    pulse(1);
    do_ret(BANK_NORM);
    wait_take(VEC_SRC1, BANK_IRQ);
    do_ret(BANK_NORM);
    run <= 1'h1;
    pin_n[2] <= 1'h0;
    no_take(24);
    pin_n[2] <= 1'h1;
    wait_take(VEC_SRC2, BANK_IRQ);
    do_ret(BANK_NORM);
    bus(1'h1, ADDR_OPT, 32'h0000_0010);
    boundary();
    pin_n[2] <= 1'h0;
    wait_take(VEC_SRC2, BANK_IRQ);
    pin_n[2] <= 1'h1;
    do_ret(BANK_NORM);
  endtask

  task automatic t_evt;
    evt_in <= 4'h6;
    @(posedge clk);
    evt_in <= 4'h0;
    bus(1'h0, ADDR_EVT, 32'h0000_0006);
    wait_take(VEC_SRC3, BANK_IRQ);
    bus(1'h1, ADDR_EVT, 32'h0000_0002);
    do_ret(BANK_NORM);
    wait_take(VEC_SRC4, BANK_IRQ);
    bus(1'h1, ADDR_EVT, 32'h0000_0004);
    bus(1'h0, ADDR_EVT, RD_ZERO);
    do_ret(BANK_NORM);
    run <= 1'h1;
    no_take(24);
  endtask

  // request seen early in an option-zero write: the guarded build still swaps banks
  task automatic t_anom;
    run <= 1'h0;
    hold_lvl <= 5'h10;
    opt_zero_wr_busy <= 1'h1;
    repeat (6) @(posedge clk);
    hold_lvl <= 5'h00;
    opt_zero_wr_busy <= 1'h0;
    wait_take(VEC_SRC4, BANK_IRQ);
    do_ret(BANK_NORM);
  endtask

  initial begin
    #100000;
    failures++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    t_reset();
    nmi_sleep(1'h0);
    bus(1'h1, ADDR_OPT, 32'h0000_0010);
    nmi_sleep(1'h1);
    t_prio();
    t_edge();
    t_evt();
    t_anom();
    print_verdict();
  end
endmodule
